// file: hw/uac_pkg.sv
// Constants shared by the serial channel and its sampling clock generator.
// Assumes a single 8-bit register file per channel, selected by a 3-bit address.
package uac_pkg;
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_IER  = 3'h1;
    localparam logic [2:0] ADDR_ISR  = 3'h2;
    localparam logic [2:0] ADDR_LCR  = 3'h3;
    localparam logic [2:0] ADDR_MCR  = 3'h4;
    localparam logic [2:0] ADDR_LSR  = 3'h5;
    localparam logic [2:0] ADDR_MSR  = 3'h6;
    localparam logic [2:0] ADDR_SCR  = 3'h7;
    localparam int LCR_DIV_EN = 7;
    localparam int LCR_BREAK  = 6;
    localparam int LCR_FORCE  = 5;
    localparam int LCR_EVEN   = 4;
    localparam int LCR_PAR_EN = 3;
    localparam int LCR_STOP   = 2;
    localparam int MCR_LOOP   = 4;
    localparam int MCR_OUT2   = 3;
    localparam int MCR_OUT1   = 2;
    localparam int MCR_RTS    = 1;
    localparam int MCR_DTR    = 0;
    localparam int IER_MODEM  = 3;
    localparam int IER_LINE   = 2;
    localparam int IER_TX     = 1;
    localparam int IER_RX     = 0;
    localparam logic [3:0] ISR_LINE = 4'h6;
    localparam logic [3:0] ISR_RX   = 4'h4;
    localparam logic [3:0] ISR_TX   = 4'h2;
    localparam logic [3:0] ISR_MSR  = 4'h0;
    localparam logic [3:0] ISR_NONE = 4'h1;
    localparam logic [7:0]  RST_IER = 8'h00;
    localparam logic [7:0]  RST_LCR = 8'h00;
    localparam logic [7:0]  RST_MCR = 8'h00;
    localparam logic [7:0]  RST_SCR = 8'h00;
    localparam logic [15:0] RST_DIV = 16'h0001;
    localparam logic [4:0] TICKS_BIT   = 5'h10;
    localparam logic [4:0] TICKS_START = 5'h08;
    localparam logic [4:0] TICKS_STOP1H = 5'h18;
    localparam logic [5:0] TICKS_STOP2 = 6'h20;
    typedef enum logic [4:0] {
        SER_IDLE   = 5'b00001,
        SER_START  = 5'b00010,
        SER_DATA   = 5'b00100,
        SER_PARITY = 5'b01000,
        SER_STOP   = 5'b10000
    } uac_ser_type;
endpackage : uac_pkg

// file: hw/uac_baud_if.sv
// Carries the divisor to the sampling clock generator and the tick back.
// Assumes both ends run on the channel clock.
`timescale 1ns/1ps
interface uac_baud_if;
    logic [15:0] divisor;
    logic        tick;
    modport gen (input divisor, output tick);
    modport use_tick (output divisor, input tick);
endinterface : uac_baud_if

// file: hw/uac_baud.sv
// Sampling clock generator: one tick every divisor clocks, 16 ticks per bit.
// Assumes the divisor is stable between host writes; zero stops the ticks.
`timescale 1ns/1ps
module uac_baud
(
    input  wire logic clk,
    input  wire logic rstn,
    uac_baud_if.gen   bus
);
    import uac_pkg::*;

    logic [15:0] count;

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            count <= 16'h0000;
            bus.tick <= 1'b0;
        end
        else if (bus.divisor == 16'h0000)
        begin
            count <= 16'h0000;
            bus.tick <= 1'b0;
        end
        else if (count >= bus.divisor - 16'h0001)
        begin
            count <= 16'h0000;
            bus.tick <= 1'b1;
        end
        else
        begin
            count <= count + 16'h0001;
            bus.tick <= 1'b0;
        end
    end
endmodule : uac_baud

// file: hw/uac_channel.sv
// One serial channel: register file, one-deep receive buffer, transmitter and loopback.
// Assumes bus strobes are synchronous to clk and held at least two clocks.
`timescale 1ns/1ps
module uac_channel
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       chan_select_n,
    input  wire logic [2:0] addr,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    input  wire logic       serial_in,
    output logic            serial_out,
    input  wire logic       clear_to_send_n,
    input  wire logic       set_ready_n,
    input  wire logic       carrier_detect_n,
    input  wire logic       ring_indicate_n,
    output logic            request_to_send_n,
    output logic            terminal_ready_n,
    output logic            general_output_one_n,
    output logic            general_output_two_n,
    output logic            irq
);
    import uac_pkg::*;

    uac_baud_if baud ();
    uac_baud u_baud (.clk(clk), .rstn(rstn), .bus(baud));

    logic [7:0]  interrupt_enable;
    logic [7:0]  line_control;
    logic [7:0]  modem_control;
    logic [7:0]  scratch;
    logic [15:0] divisor;
    logic [7:0]  transmit_holding;
    logic        thr_full;
    logic [7:0]  receive_holding;
    logic [2:0]  rx_tags;
    logic        data_ready;
    logic        overrun;
    logic        tx_irq;
    logic [3:0]  modem_prev;
    logic [3:0]  modem_delta;
    logic        rd_prev;
    logic        wr_prev;
    logic [7:0]  read_value;
    logic [3:0]  isr_code;
    logic [3:0]  modem_now;
    logic        loop;
    logic        rd_start;
    logic        wr_start;
    logic        div_en;
    logic [2:0]  last_bit;

    // Serial engines
    uac_ser_type tx_state;
    uac_ser_type rx_state;
    logic [5:0]  tx_cnt;
    logic [2:0]  tx_bit;
    logic [7:0]  tx_shifter;
    logic        tx_line;
    logic        tx_feed;
    logic [5:0]  stop_ticks;
    logic        thr_take;
    logic [4:0]  rx_cnt;
    logic [2:0]  rx_bit;
    logic [7:0]  receive_shifter;
    logic        rx_pbit;
    logic        rx_perr;
    logic        rx_in;
    logic        rx_done;
    logic [2:0]  rx_new_tags;

    function automatic logic [7:0] mask_word(input logic [7:0] d, input logic [2:0] last);
        mask_word = d & (8'hFF >> (3'h7 - last));
    endfunction : mask_word

    function automatic logic parity_bit(input logic [7:0] lc, input logic [7:0] d);
        if (lc[LCR_FORCE])
            parity_bit = ~lc[LCR_EVEN];
        else
            parity_bit = lc[LCR_EVEN] ? ^d : ~^d;
    endfunction : parity_bit

    assign loop       = modem_control[MCR_LOOP];
    assign div_en     = line_control[LCR_DIV_EN];
    assign last_bit   = {1'b0, line_control[1:0]} + 3'h4;
    assign rd_start   = !chan_select_n && !rd_n && !rd_prev;
    assign wr_start   = !chan_select_n && !wr_n && !wr_prev;
    assign baud.divisor = divisor;
    assign tx_feed    = line_control[LCR_BREAK] ? 1'b0 : tx_line;
    assign rx_in      = loop ? tx_feed : serial_in;
    assign thr_take   = thr_full && (tx_state == SER_IDLE);

    // Loopback maps the modem outputs back onto the status inputs
    assign modem_now = loop ? {modem_control[MCR_OUT2], modem_control[MCR_OUT1],
                               modem_control[MCR_DTR], modem_control[MCR_RTS]}
                            : {~carrier_detect_n, ~ring_indicate_n,
                               ~set_ready_n, ~clear_to_send_n};

    always_comb
    begin
        if (!line_control[LCR_STOP])
            stop_ticks = {1'b0, TICKS_BIT};
        else if (line_control[1:0] == 2'b00)
            stop_ticks = {1'b0, TICKS_STOP1H};
        else
            stop_ticks = TICKS_STOP2;
    end

    // Priority: line status, receive data, transmit ready, modem status
    always_comb
    begin
        if (interrupt_enable[IER_LINE] && (overrun || rx_tags != 3'h0))
            isr_code = ISR_LINE;
        else if (interrupt_enable[IER_RX] && data_ready)
            isr_code = ISR_RX;
        else if (interrupt_enable[IER_TX] && tx_irq)
            isr_code = ISR_TX;
        else if (interrupt_enable[IER_MODEM] && modem_delta != 4'h0)
            isr_code = ISR_MSR;
        else
            isr_code = ISR_NONE;
    end

    always_comb
    begin
        case (addr)
            ADDR_DATA: read_value = div_en ? divisor[7:0] : receive_holding;
            ADDR_IER:  read_value = div_en ? divisor[15:8] : {4'h0, interrupt_enable[3:0]};
            ADDR_ISR:  read_value = {4'h0, isr_code};
            ADDR_LCR:  read_value = line_control;
            ADDR_MCR:  read_value = {3'h0, modem_control[4:0]};
            ADDR_LSR:  read_value = {1'b0, !thr_full && tx_state == SER_IDLE, !thr_full,
                                     rx_tags, overrun, data_ready};
            ADDR_MSR:  read_value = {modem_now, modem_delta};
            ADDR_SCR:  read_value = scratch;
            default:   read_value = 8'h00;
        endcase
    end

    // Bus strobe edges and read data
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            rd_prev <= 1'b0;
            wr_prev <= 1'b0;
            data_out <= 8'h00;
            data_oe <= 1'b0;
        end
        else
        begin
            rd_prev <= !chan_select_n && !rd_n;
            wr_prev <= !chan_select_n && !wr_n;
            data_oe <= !chan_select_n && !rd_n;
            if (rd_start)
                data_out <= read_value;
        end
    end

    // Host-written registers; writes to the status addresses are dropped
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            interrupt_enable <= RST_IER;
            line_control <= RST_LCR;
            modem_control <= RST_MCR;
            scratch <= RST_SCR;
            divisor <= RST_DIV;
        end
        else if (wr_start)
        begin
            case (addr)
                ADDR_DATA: if (div_en) divisor[7:0] <= data_in;
                ADDR_IER:
                begin
                    if (div_en)
                        divisor[15:8] <= data_in;
                    else
                        interrupt_enable <= {4'h0, data_in[3:0]};
                end
                ADDR_LCR:  line_control <= data_in;
                ADDR_MCR:  modem_control <= {3'h0, data_in[4:0]};
                ADDR_SCR:  scratch <= data_in;
                default:   ;
            endcase
        end
    end

    // Transmit holding register and transmit-ready interrupt
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            transmit_holding <= 8'h00;
            thr_full <= 1'b0;
            tx_irq <= 1'b0;
        end
        else
        begin
            if (wr_start && addr == ADDR_DATA && !div_en)
            begin
                transmit_holding <= data_in;
                thr_full <= 1'b1;
            end
            else if (thr_take)
                thr_full <= 1'b0;
            // Becoming empty or enabling while empty wins over a clear
            if (thr_take || (wr_start && addr == ADDR_IER && !div_en && data_in[IER_TX]
                             && !interrupt_enable[IER_TX] && !thr_full))
                tx_irq <= 1'b1;
            else if (wr_start && addr == ADDR_DATA && !div_en)
                tx_irq <= 1'b0;
            else if (rd_start && addr == ADDR_ISR && isr_code == ISR_TX)
                tx_irq <= 1'b0;
        end
    end

    // Transmitter: start, data, optional parity, stop
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            tx_state <= SER_IDLE;
            tx_cnt <= 6'h00;
            tx_bit <= 3'h0;
            tx_shifter <= 8'h00;
            tx_line <= 1'b1;
        end
        else
        begin
            case (tx_state)
                SER_IDLE:
                begin
                    tx_line <= 1'b1;
                    if (thr_take)
                    begin
                        tx_shifter <= mask_word(transmit_holding, last_bit);
                        tx_state <= SER_START;
                        tx_cnt <= 6'h00;
                        tx_line <= 1'b0;
                    end
                end
                SER_START, SER_DATA, SER_PARITY:
                begin
                    if (baud.tick)
                    begin
                        tx_cnt <= tx_cnt + 6'h01;
                        if (tx_cnt == {1'b0, TICKS_BIT - 5'h01})
                        begin
                            tx_cnt <= 6'h00;
                            if (tx_state == SER_START)
                            begin
                                tx_state <= SER_DATA;
                                tx_bit <= 3'h0;
                                tx_line <= tx_shifter[0];
                            end
                            else if (tx_state == SER_DATA && tx_bit != last_bit)
                            begin
                                tx_bit <= tx_bit + 3'h1;
                                tx_line <= tx_shifter[tx_bit + 3'h1];
                            end
                            else if (tx_state == SER_DATA && line_control[LCR_PAR_EN])
                            begin
                                tx_state <= SER_PARITY;
                                tx_line <= parity_bit(line_control, tx_shifter);
                            end
                            else
                            begin
                                tx_state <= SER_STOP;
                                tx_line <= 1'b1;
                            end
                        end
                    end
                end
                SER_STOP:
                begin
                    if (baud.tick)
                    begin
                        tx_cnt <= tx_cnt + 6'h01;
                        if (tx_cnt == stop_ticks - 6'h01)
                            tx_state <= SER_IDLE;
                    end
                end
                default:   tx_state <= SER_IDLE;
            endcase
        end
    end

    // Pins: loopback parks the line at mark and drops request-to-send and terminal-ready; OUT1 and OUT2 still follow modem control
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            serial_out <= 1'b1;
            request_to_send_n <= 1'b1;
            terminal_ready_n <= 1'b1;
            general_output_one_n <= 1'b1;
            general_output_two_n <= 1'b1;
            irq <= 1'b0;
        end
        else
        begin
            serial_out <= loop ? 1'b1 : tx_feed;
            request_to_send_n <= loop ? 1'b1 : ~modem_control[MCR_RTS];
            terminal_ready_n <= loop ? 1'b1 : ~modem_control[MCR_DTR];
            general_output_one_n <= ~modem_control[MCR_OUT1];
            general_output_two_n <= ~modem_control[MCR_OUT2];
            irq <= modem_control[MCR_OUT2] && !isr_code[0];
        end
    end

    // Receiver: line samples at mid-bit by counting sampling ticks
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            rx_state <= SER_IDLE;
            rx_cnt <= 5'h00;
            rx_bit <= 3'h0;
            receive_shifter <= 8'h00;
            rx_pbit <= 1'b0;
            rx_perr <= 1'b0;
            rx_done <= 1'b0;
            rx_new_tags <= 3'h0;
        end
        else
        begin
            rx_done <= 1'b0;
            if (baud.tick)
            begin
                rx_cnt <= rx_cnt + 5'h01;
                case (rx_state)
                    SER_IDLE:
                    begin
                        rx_cnt <= 5'h00;
                        if (!rx_in)
                            rx_state <= SER_START;
                    end
                    SER_START:
                    begin
                        if (rx_cnt == TICKS_START - 5'h02)
                        begin
                            rx_cnt <= 5'h00;
                            rx_bit <= 3'h0;
                            receive_shifter <= 8'h00;
                            rx_pbit <= 1'b0;
                            rx_state <= rx_in ? SER_IDLE : SER_DATA;
                        end
                    end
                    SER_DATA:
                    begin
                        if (rx_cnt == TICKS_BIT - 5'h01)
                        begin
                            rx_cnt <= 5'h00;
                            receive_shifter[rx_bit] <= rx_in;
                            rx_bit <= rx_bit + 3'h1;
                            if (rx_bit == last_bit)
                                rx_state <= line_control[LCR_PAR_EN] ? SER_PARITY : SER_STOP;
                        end
                    end
                    SER_PARITY:
                    begin
                        if (rx_cnt == TICKS_BIT - 5'h01)
                        begin
                            rx_cnt <= 5'h00;
                            rx_pbit <= rx_in;
                            rx_perr <= rx_in != parity_bit(line_control, receive_shifter);
                            rx_state <= SER_STOP;
                        end
                    end
                    SER_STOP:
                    begin
                        if (rx_cnt == TICKS_BIT - 5'h01)
                        begin
                            rx_state <= SER_IDLE;
                            rx_done <= 1'b1;
                            // Tags: break, framing, parity
                            rx_new_tags <= {receive_shifter == 8'h00 && !rx_pbit && !rx_in, !rx_in,
                                            line_control[LCR_PAR_EN] && rx_perr};
                        end
                    end
                    default:   rx_state <= SER_IDLE;
                endcase
            end
        end
    end

    // One-deep receive buffer; a character completed while data is still unread overwrites it and flags overrun
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            receive_holding <= 8'h00;
            rx_tags <= 3'h0;
            data_ready <= 1'b0;
            overrun <= 1'b0;
        end
        else
        begin
            if (rx_done)
            begin
                receive_holding <= receive_shifter;
                rx_tags <= rx_new_tags;
                data_ready <= 1'b1;
            end
            else if (rd_start && addr == ADDR_DATA && !div_en)
            begin
                data_ready <= 1'b0;
                rx_tags <= 3'h0;
            end
            else if (rd_start && addr == ADDR_LSR)
                rx_tags <= 3'h0;
            if (rx_done && data_ready && !(rd_start && addr == ADDR_DATA && !div_en))
                overrun <= 1'b1;
            else if (rd_start && addr == ADDR_LSR)
                overrun <= 1'b0;
        end
    end

    // Modem change flags; a change in the read cycle survives the read
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            modem_prev <= 4'h0;
            modem_delta <= 4'h0;
        end
        else
        begin
            modem_prev <= modem_now;
            if (rd_start && addr == ADDR_MSR)
                modem_delta <= modem_now ^ modem_prev;
            else
                modem_delta <= modem_delta | (modem_now ^ modem_prev);
        end
    end
endmodule : uac_channel

// file: tb/uac_remote.sv
// Remote serial device driving the channel's receive line.
// Assumes divisor 1, so one bit lasts 16 clocks.
`timescale 1ns/1ps
module uac_remote
(
    input wire logic clk,
    output logic     serial_in
);
    initial serial_in = 1'b1;
    task automatic send(input logic [7:0] d, input int wl, input logic stop);
        serial_in <= 1'b0;
        repeat (16) @(posedge clk);
        for (int i = 0; i < wl; i++)
        begin
            serial_in <= d[i];
            repeat (16) @(posedge clk);
        end
        serial_in <= stop;
        // A low stop is let go just after its mid-sample; the start it then raises fails the mid-start check
        repeat (stop ? 16 : 9) @(posedge clk);
        serial_in <= 1'b1;
        repeat (16) @(posedge clk);
    endtask : send
endmodule : uac_remote

// file: tb/uac_channel_monitor.sv
// Port checker bound into every serial channel.
// Assumes host strobes keep the bus contract.
`timescale 1ns/1ps
module uac_channel_monitor
    import uac_pkg::*;
(
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       chan_select_n,
    input wire logic [2:0] addr,
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic       data_oe,
    input wire logic       serial_out,
    input wire logic       request_to_send_n,
    input wire logic       terminal_ready_n,
    input wire logic       general_output_two_n,
    input wire logic       irq
);
    logic       rd_q;
    logic       wr_q;
    logic [7:0] mcr_q;
    wire        rd_go = !chan_select_n && !rd_n && !rd_q;
    // Shadow of modem control, taken at the strobe start like the device
    always_ff @(posedge clk)
    begin
        rd_q <= !chan_select_n && !rd_n;
        wr_q <= !chan_select_n && !wr_n;
        if (!rstn)
            mcr_q <= RST_MCR;
        else if (!chan_select_n && !wr_n && !wr_q && addr == ADDR_MCR)
            mcr_q <= data_in;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    oe_lag_a: assert property (data_oe == rd_q)
        else $error("oe lag");
    loop_pins_a: assert property (mcr_q[4] && $past(mcr_q[4], 3) |-> serial_out && request_to_send_n && terminal_ready_n)
        else $error("loop pins");
    modem_out_a: assert property (!mcr_q[4] && mcr_q == $past(mcr_q, 3) |->
        {request_to_send_n, terminal_ready_n} == ~mcr_q[1:0]) else $error("modem out");
    out_two_a: assert property (mcr_q == $past(mcr_q, 3) |-> general_output_two_n == !mcr_q[3])
        else $error("out two");
    irq_gate_a: assert property (!mcr_q[3] && !$past(mcr_q[3], 3) |-> !irq)
        else $error("irq gate");
    isr_high_a: assert property (rd_go && addr == ADDR_ISR |=> data_out[7:4] == 4'h0)
        else $error("isr high");
    lsr_top_a: assert property (rd_go && addr == ADDR_LSR |=> !data_out[7])
        else $error("lsr top");
    dout_hold_a: assert property (!rd_go |=> $stable(data_out))
        else $error("dout hold");
    cover property (rd_go && addr == ADDR_DATA);
    cover property (mcr_q[4] && rd_go);
    cover property (irq);
endmodule : uac_channel_monitor

bind uac_channel uac_channel_monitor i_uac_channel_monitor (.clk, .rstn, .chan_select_n, .addr, .rd_n, .wr_n,
    .data_in, .data_out, .data_oe, .serial_out, .request_to_send_n, .terminal_ready_n, .general_output_two_n, .irq);

// file: tb/uart_channel_registers_loopback_tb_top.sv
// Self-checking bench: registers, loopback and external receive.
// Assumes divisor 1, so one serial bit lasts 16 clocks.
`timescale 1ns/1ps
module uart_channel_registers_loopback_tb_top;
    import uac_pkg::*;
    logic       clk = 1'b0, rstn = 1'b0, chan_select_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] data_in = 8'h00, data_out, v, b;
    logic [3:0] mi = 4'hF;
    logic       data_oe, serial_in, serial_out, irq;
    int         mismatches = 0, n_checks = 0;
    always #25 clk = ~clk;
    uac_channel i_uac_channel (.clk, .rstn, .chan_select_n, .addr, .rd_n, .wr_n, .data_in, .data_out,
        .data_oe, .serial_in, .serial_out, .clear_to_send_n(mi[0]), .set_ready_n(mi[1]),
        .carrier_detect_n(mi[3]), .ring_indicate_n(mi[2]), .request_to_send_n(), .terminal_ready_n(),
        .general_output_one_n(), .general_output_two_n(), .irq);
    uac_remote i_uac_remote (.clk, .serial_in);
    function automatic logic [7:0] rx_exp(input logic [7:0] d, input int wl);
        return d & (8'hFF >> (8 - wl));
    endfunction : rx_exp
    // Strobe held two clocks, then two idle clocks before the next access
    task automatic acc(input logic w, input logic [2:0] ad, input logic [7:0] d);
        @(posedge clk);
        {chan_select_n, rd_n, wr_n, addr, data_in} <= {1'b0, w, !w, ad, d};
        repeat (2) @(posedge clk);
        v = data_out;
        {chan_select_n, rd_n, wr_n} <= 3'h7;
        @(posedge clk);
    endtask : acc
    task automatic rdc(input string n, input logic [2:0] ad, input logic [7:0] e);
        acc(1'b0, ad, 8'h00);
        n_checks++;
        if (v !== e)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", n, e, v);
        end
    endtask : rdc
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        tally_and_finish;
    end
    initial
    begin
        void'($urandom(32'h3111C5A5));
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        rdc("ier", ADDR_IER, RST_IER);
        rdc("isr", ADDR_ISR, 8'h01);
        for (int i = 0; i < 6; i++)
        begin
            b = 8'($urandom);
            acc(1'b1, ADDR_SCR, b);
            acc(1'b1, i[0] ? ADDR_LSR : ADDR_ISR, ~b);
            rdc("scratch", ADDR_SCR, b);
        end
        rdc("lsr", ADDR_LSR, 8'h60);
        acc(1'b1, ADDR_LCR, 8'h80);
        acc(1'b1, ADDR_DATA, ~b);
        acc(1'b1, ADDR_IER, b);
        rdc("div lo", ADDR_DATA, ~b);
        rdc("div hi", ADDR_IER, b);
        acc(1'b1, ADDR_DATA, 8'h01);
        acc(1'b1, ADDR_IER, 8'h00);
        acc(1'b1, ADDR_LCR, 8'h03);
        acc(1'b1, ADDR_IER, 8'hFF);
        rdc("ier", ADDR_IER, 8'h0F);
        $display("test registers done");
        acc(1'b1, ADDR_MCR, 8'hFF);
        rdc("mcr", ADDR_MCR, 8'h1F);
        acc(1'b1, ADDR_DATA, b);
        repeat (250) @(posedge clk);
        rdc("lsr", ADDR_LSR, 8'h61);
        n_checks++;
        if (irq !== 1'b1)
        begin
            mismatches++;
            $display("unexpected irq: expected 1 seen %b", irq);
        end
        rdc("rx", ADDR_DATA, b);
        $display("test loopback done");
        acc(1'b1, ADDR_MCR, 8'h08);
        acc(1'b0, ADDR_MSR, 8'h00);
        b = 8'($urandom);
        mi <= b[3:0];
        rdc("msr", ADDR_MSR, {~b[3:0], ~b[3:0]});
        for (int wl = 5; wl < 9; wl++)
        begin
            b = 8'($urandom) | 8'h01;
            acc(1'b1, ADDR_LCR, 8'(wl - 5));
            i_uac_remote.send(b, wl, 1'b1);
            rdc("rx", ADDR_DATA, rx_exp(b, wl));
        end
        i_uac_remote.send(8'hA5, 8, 1'b0);
        rdc("lsr", ADDR_LSR, 8'h69);
        i_uac_remote.send(8'h3C, 8, 1'b1);
        rdc("lsr", ADDR_LSR, 8'h63);
        rdc("rx", ADDR_DATA, 8'h3C);
        $display("test serial done");
        tally_and_finish;
    end
endmodule : uart_channel_registers_loopback_tb_top
